//--- core/dcirq_defs.vh
// Constants for the converter control and interrupt register bank.
// Assumes one 20 MHz clock and a slow three-wire serial control port.
// Functional notes
// [R1] Serial port shifts MSB first when bit-order bit is 0, LSB first if 1.
// [R2] Writing 1 to soft reset bit resets everything; it always reads 0.
// [R3] In-phase power-down bit stops only that converter's analog part.
// [R4] Quadrature power-down bit stops only that converter's analog part.
// [R5] Data receiver power-down disables data input and FIFO write side.
// [R6] Chip power-down bit powers down bandgap and whole chip.
// [R7] Sample-clock power-down stops clock path and most digital logic.
// [R8] Frame power-down disables frame receiver, internal frame held low.
// [R9] Main enable register: one enable per sync, PLL, threshold, mute event.
// [R10] FIFO enable register: underflow bit 2, overflow bit 1, warning bit 0.
// [R11] Flags 6, 5, 4 set on sync lost, sync locked, sync done.
// [R12] Flags 3 and 2 set on PLL lock lost and PLL locked.
// [R13] Flag 1 set when input power exceeds threshold.
// [R14] Flag 0 set when converter output is muted to midscale.
// [R15] FIFO flags: underflow, overflow, warning at level <=1 or >=6.
// [R16] Per-event select bit routes event to pin A (0) or pin B (1).
// [R17] A pin asserts while any enabled flag routed to it is set.
// [R18] All registers return to reset values on power-on or soft reset.
`ifndef DCIRQ_DEFS_VH
`define DCIRQ_DEFS_VH

`define DCIRQ_ADDR_W          7
`define DCIRQ_ADDR_SPI_CFG    7'h00
`define DCIRQ_ADDR_PD_CTRL    7'h01
`define DCIRQ_ADDR_EN_MAIN    7'h03
`define DCIRQ_ADDR_EN_FIFO    7'h04
`define DCIRQ_ADDR_FLAG_MAIN  7'h05
`define DCIRQ_ADDR_FLAG_FIFO  7'h06
`define DCIRQ_ADDR_SEL_MAIN   7'h07
`define DCIRQ_ADDR_SEL_FIFO   7'h08

`define DCIRQ_BIT_LSB_FIRST   6
`define DCIRQ_BIT_SOFT_RESET  5

`define DCIRQ_BIT_PD_INPHASE  7
`define DCIRQ_BIT_PD_QUAD     6
`define DCIRQ_BIT_PD_DATA     5
`define DCIRQ_BIT_PD_CHIP     2
`define DCIRQ_BIT_PD_CLOCK    1
`define DCIRQ_BIT_RECEIVER_A    0
`define DCIRQ_PD_MASK         8'hE7

`define DCIRQ_RST_SPI_CFG     1'b0
`define DCIRQ_RST_PD_CTRL     8'hC0
`define DCIRQ_RST_EN_MAIN     7'h00
`define DCIRQ_RST_EN_FIFO     3'h0
`define DCIRQ_RST_SEL_MAIN    7'h00
`define DCIRQ_RST_SEL_FIFO    3'h0
`define DCIRQ_RST_FLAGS       10'h000

`define DCIRQ_N_MAIN          7
`define DCIRQ_N_FIFO          3
`define DCIRQ_N_EVT           10

`define DCIRQ_FIFO_LOW_MARK   3'h1
`define DCIRQ_FIFO_HIGH_MARK  3'h6

`define DCIRQ_INSTR_BITS      5'h08
`define DCIRQ_XFER_BITS       5'h10

`endif

//--- core/dcirq_regs.v
// Control, power-down and interrupt registers behind a 3-wire serial port.
// Assumes serial clock well below clock/8 and same-clock event inputs.
`default_nettype none
`include "dcirq_defs.vh"

module dcirq_regs #(
    parameter LEVEL_W = 3
) (
    input  wire               clock,
    input  wire               rst,
    input  wire               spi_sclk,
    input  wire               spi_csb_n,
    input  wire               spi_sdio_in,
    output reg                spi_sdio_out,
    output reg                spi_sdio_oe,
    input  wire               evt_sync_lost,
    input  wire               evt_sync_locked,
    input  wire               evt_sync_done,
    input  wire               evt_pll_lost,
    input  wire               evt_pll_locked,
    input  wire               evt_over_threshold,
    input  wire               evt_output_muted,
    input  wire               evt_fifo_underflow,
    input  wire               evt_fifo_overflow,
    input  wire [LEVEL_W-1:0] fifo_level,
    input  wire               frame_pin,
    output reg                lsb_first,
    output reg                soft_reset_pulse,
    output reg                pd_inphase_converter,
    output reg                pd_quadrature_converter,
    output reg                pd_data_receiver,
    output reg                pd_whole_chip,
    output reg                pd_sample_clock_path,
    output reg                receiver_a,
    output reg                frame_int,
    output reg                interrupt_out_a,
    output reg                interrupt_out_b
);

    wire [3:0] pin_sync;
    wire       sclk_s;
    wire       csb_s;
    wire       sdio_s;
    wire       frame_s;

    // Pins enter the clock domain here; nothing reads them earlier
    dcirq_sync #(
        .W (4)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({frame_pin, spi_sdio_in, spi_csb_n, spi_sclk}),
        .sync_out (pin_sync)
    );

    assign sclk_s  = pin_sync[0];
    assign csb_s   = pin_sync[1];
    assign sdio_s  = pin_sync[2];
    assign frame_s = pin_sync[3];

    // Register state
    reg                     lsb_first_reg;
    reg  [7:0]              pd_reg;
    reg  [`DCIRQ_N_MAIN-1:0] en_main_reg;
    reg  [`DCIRQ_N_FIFO-1:0] en_fifo_reg;
    reg  [`DCIRQ_N_MAIN-1:0] sel_main_reg;
    reg  [`DCIRQ_N_FIFO-1:0] sel_fifo_reg;
    reg  [`DCIRQ_N_EVT-1:0]  flag_reg;
    reg                     soft_rst_reg;

    // Serial engine state
    reg                     sclk_d_reg;
    reg  [4:0]              bit_cnt_reg;
    reg  [7:0]              shift_reg;
    reg  [7:0]              tx_reg;
    reg                     rd_reg;
    reg  [`DCIRQ_ADDR_W-1:0] addr_reg;
    reg                     order_reg;

    wire rst_all;
    wire sclk_rise;
    wire sclk_fall;
    wire [7:0] shift_next;
    wire instr_done;
    wire data_done;
    wire wr_stb;

    // Power-on reset or self-clearing soft reset
    assign rst_all    = rst | soft_rst_reg; // [R18]
    assign sclk_rise  = ~csb_s & sclk_s & ~sclk_d_reg;
    assign sclk_fall  = ~csb_s & ~sclk_s & sclk_d_reg;
    // Bit order: received word lands in the same layout either way
    assign shift_next = order_reg ? {sdio_s, shift_reg[7:1]}
                                  : {shift_reg[6:0], sdio_s}; // [R1]
    assign instr_done = sclk_rise &
                        (bit_cnt_reg == `DCIRQ_INSTR_BITS - 5'h01);
    assign data_done  = sclk_rise &
                        (bit_cnt_reg == `DCIRQ_XFER_BITS - 5'h01);
    assign wr_stb     = data_done & ~rd_reg;

    // Read data multiplexer
    reg [7:0] rd_data;
    always @* begin
        rd_data = 8'h00;
        case (shift_next[`DCIRQ_ADDR_W-1:0])
            `DCIRQ_ADDR_SPI_CFG: begin
                // Soft reset bit always reads as zero
                rd_data[`DCIRQ_BIT_LSB_FIRST] = lsb_first_reg; // [R2]
            end
            `DCIRQ_ADDR_PD_CTRL: begin
                rd_data = pd_reg;
            end
            `DCIRQ_ADDR_EN_MAIN: begin
                rd_data = {1'b0, en_main_reg};
            end
            `DCIRQ_ADDR_EN_FIFO: begin
                rd_data = {5'h00, en_fifo_reg};
            end
            `DCIRQ_ADDR_FLAG_MAIN: begin
                rd_data = {1'b0, flag_reg[6:0]};
            end
            `DCIRQ_ADDR_FLAG_FIFO: begin
                rd_data = {5'h00, flag_reg[9:7]};
            end
            `DCIRQ_ADDR_SEL_MAIN: begin
                rd_data = {1'b0, sel_main_reg};
            end
            `DCIRQ_ADDR_SEL_FIFO: begin
                rd_data = {5'h00, sel_fifo_reg};
            end
            default: begin
                // Unmapped addresses read as zero
                rd_data = 8'h00;
            end
        endcase
    end

    // Serial transfer engine
    always @(posedge clock) begin
        if (rst_all) begin
            sclk_d_reg   <= 1'b0;
            bit_cnt_reg  <= 5'h00;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            rd_reg       <= 1'b0;
            addr_reg     <= {`DCIRQ_ADDR_W{1'b0}};
            order_reg    <= 1'b0;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe  <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            if (csb_s) begin
                // Idle: order latched for the next transfer
                bit_cnt_reg <= 5'h00;
                order_reg   <= lsb_first_reg; // [R1]
                spi_sdio_oe <= 1'b0;
                rd_reg      <= 1'b0;
            end else begin
                // Data pin taken on each synchronised clock rise
                if (sclk_rise) begin
                    shift_reg <= shift_next;
                    if (bit_cnt_reg != `DCIRQ_XFER_BITS) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                // Instruction complete: read word captured early
                if (instr_done) begin
                    rd_reg   <= shift_next[7];
                    addr_reg <= shift_next[`DCIRQ_ADDR_W-1:0];
                    tx_reg   <= rd_data;
                end
                // Read bits change only after a falling clock edge
                if (sclk_fall && rd_reg &&
                    bit_cnt_reg >= `DCIRQ_INSTR_BITS &&
                    bit_cnt_reg <  `DCIRQ_XFER_BITS) begin
                    spi_sdio_oe <= 1'b1;
                    if (order_reg) begin
                        spi_sdio_out <= tx_reg[0]; // [R1]
                        tx_reg       <= {1'b0, tx_reg[7:1]};
                    end else begin
                        spi_sdio_out <= tx_reg[7]; // [R1]
                        tx_reg       <= {tx_reg[6:0], 1'b0};
                    end
                end
                // Line released after the last bit
                if (sclk_fall && bit_cnt_reg == `DCIRQ_XFER_BITS) begin
                    spi_sdio_oe <= 1'b0;
                end
            end
        end
    end

    // Writable registers
    always @(posedge clock) begin
        if (rst_all) begin
            lsb_first_reg <= `DCIRQ_RST_SPI_CFG; // [R18]
            pd_reg        <= `DCIRQ_RST_PD_CTRL;
            en_main_reg   <= `DCIRQ_RST_EN_MAIN; // [R9]
            en_fifo_reg   <= `DCIRQ_RST_EN_FIFO; // [R10]
            sel_main_reg  <= `DCIRQ_RST_SEL_MAIN;
            sel_fifo_reg  <= `DCIRQ_RST_SEL_FIFO;
            soft_rst_reg  <= 1'b0;
        end else begin
            soft_rst_reg <= 1'b0;
            if (wr_stb) begin
                case (addr_reg)
                    `DCIRQ_ADDR_SPI_CFG: begin
                        lsb_first_reg <= shift_next[`DCIRQ_BIT_LSB_FIRST];
                        soft_rst_reg  <=
                            shift_next[`DCIRQ_BIT_SOFT_RESET]; // [R2]
                    end
                    `DCIRQ_ADDR_PD_CTRL: begin
                        // Reserved bits 4:3 stay zero
                        pd_reg <= shift_next & `DCIRQ_PD_MASK;
                    end
                    `DCIRQ_ADDR_EN_MAIN: begin
                        en_main_reg <= shift_next[6:0]; // [R9]
                    end
                    `DCIRQ_ADDR_EN_FIFO: begin
                        en_fifo_reg <= shift_next[2:0]; // [R10]
                    end
                    `DCIRQ_ADDR_SEL_MAIN: begin
                        sel_main_reg <= shift_next[6:0]; // [R16]
                    end
                    `DCIRQ_ADDR_SEL_FIFO: begin
                        sel_fifo_reg <= shift_next[2:0]; // [R16]
                    end
                    default: begin
                        // Flag clears handled elsewhere; unmapped writes ignored
                    end
                endcase
            end
        end
    end

    // Event sources, flag order: fifo[9:7], main[6:0]
    wire                    fifo_warn;
    wire [`DCIRQ_N_EVT-1:0] evt_vec;
    wire [`DCIRQ_N_EVT-1:0] clr_vec;
    wire [`DCIRQ_N_MAIN-1:0] clr_main;
    wire [`DCIRQ_N_FIFO-1:0] clr_fifo;
    wire [`DCIRQ_N_EVT-1:0] en_vec;
    wire [`DCIRQ_N_EVT-1:0] sel_vec;

    assign fifo_warn = (fifo_level <= `DCIRQ_FIFO_LOW_MARK) ||
                       (fifo_level >= `DCIRQ_FIFO_HIGH_MARK); // [R15]
    assign evt_vec = {evt_fifo_underflow,               // [R15]
                      evt_fifo_overflow,
                      fifo_warn,
                      evt_sync_lost,                    // [R11]
                      evt_sync_locked,
                      evt_sync_done,
                      evt_pll_lost,                     // [R12]
                      evt_pll_locked,
                      evt_over_threshold,               // [R13]
                      evt_output_muted};                // [R14]
    // Write one to a flag bit clears it
    assign clr_fifo = (wr_stb && addr_reg == `DCIRQ_ADDR_FLAG_FIFO) ?
                      shift_next[2:0] : 3'h0;
    assign clr_main = (wr_stb && addr_reg == `DCIRQ_ADDR_FLAG_MAIN) ?
                      shift_next[6:0] : 7'h00;
    assign clr_vec  = {clr_fifo, clr_main};
    assign en_vec  = {en_fifo_reg, en_main_reg};
    assign sel_vec = {sel_fifo_reg, sel_main_reg};

    // Sticky flags, event wins over a same-cycle clear
    genvar i;
    generate
        for (i = 0; i < `DCIRQ_N_EVT; i = i + 1) begin : g_flag
            always @(posedge clock) begin
                if (rst_all) begin
                    flag_reg[i] <= 1'b0;
                end else if (evt_vec[i]) begin
                    flag_reg[i] <= 1'b1; // [R11]
                end else if (clr_vec[i]) begin
                    flag_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Outputs, all registered
    wire [`DCIRQ_N_EVT-1:0] live_vec;
    assign live_vec = flag_reg & en_vec; // [R17]

    always @(posedge clock) begin
        if (rst_all) begin
            lsb_first               <= `DCIRQ_RST_SPI_CFG;
            soft_reset_pulse        <= 1'b0;
            pd_inphase_converter    <= 1'b1;
            pd_quadrature_converter <= 1'b1;
            pd_data_receiver        <= 1'b0;
            pd_whole_chip           <= 1'b0;
            pd_sample_clock_path    <= 1'b0;
            receiver_a              <= 1'b0;
        end else begin
            lsb_first               <= lsb_first_reg;
            soft_reset_pulse        <= wr_stb &&
                addr_reg == `DCIRQ_ADDR_SPI_CFG &&
                shift_next[`DCIRQ_BIT_SOFT_RESET]; // [R2]
            pd_inphase_converter    <= pd_reg[`DCIRQ_BIT_PD_INPHASE]; // [R3]
            pd_quadrature_converter <= pd_reg[`DCIRQ_BIT_PD_QUAD]; // [R4]
            pd_data_receiver        <= pd_reg[`DCIRQ_BIT_PD_DATA]; // [R5]
            pd_whole_chip           <= pd_reg[`DCIRQ_BIT_PD_CHIP]; // [R6]
            pd_sample_clock_path    <= pd_reg[`DCIRQ_BIT_PD_CLOCK]; // [R7]
            receiver_a              <= pd_reg[`DCIRQ_BIT_RECEIVER_A]; // [R8]
        end
    end

    // Frame held low while its receiver is powered down
    always @(posedge clock) begin
        if (rst_all) begin
            frame_int <= 1'b0;
        end else begin
            frame_int <= frame_s & ~pd_reg[`DCIRQ_BIT_RECEIVER_A]; // [R8]
        end
    end

    // Pin levels follow the flags one cycle late
    always @(posedge clock) begin
        if (rst_all) begin
            interrupt_out_a <= 1'b0;
            interrupt_out_b <= 1'b0;
        end else begin
            interrupt_out_a <= |(live_vec & ~sel_vec); // [R16]
            interrupt_out_b <= |(live_vec & sel_vec);  // [R17]
        end
    end

endmodule

`default_nettype wire

//--- core/dcirq_sync.v
// Two-stage synchroniser for pins entering the clock domain.
// Assumes the inputs are asynchronous levels; first stage feeds only second.
`default_nettype none

module dcirq_sync #(
    parameter W = 4
) (
    input  wire         clock,
    input  wire         rst,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta_reg;

    always @(posedge clock) begin
        if (rst) begin
            meta_reg <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

//--- verif/dcirq_host.sv
// Host model driving the three-wire serial control port.
// Assumes the device samples on sclk rise and drives after sclk fall.
`default_nettype none
module dcirq_host (
    input  wire logic clock,
    output var  logic spi_sclk,
    output var  logic spi_csb_n,
    output wire logic spi_sdio_in,
    input  wire logic spi_sdio_out,
    input  wire logic spi_sdio_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv;
    logic dat;
    logic alt;
    // Undriven line wanders instead of holding its last value
    assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : (drv ? dat : alt);
    initial begin
        spi_sclk = 1'b0;
        spi_csb_n = 1'b1;
        drv = 1'b0;
        dat = 1'b0;
        alt = 1'b0;
    end
    always @(posedge clock) alt <= ~alt;
    task automatic xfer(input logic rd, input logic [6:0] addr,
                        input logic [7:0] wdata, input logic lsb,
                        output logic [7:0] rdata);
        logic [15:0] word;
        int i;
        word = {rd, addr, wdata};
        rdata = 8'h00;
        @(posedge clock);
        spi_csb_n <= 1'b0;
        for (i = 0; i < 16; i++) begin
            drv <= (i < 8) || !rd;
            dat <= lsb ? word[(i < 8) ? 8 + i : i - 8] : word[15 - i];
            repeat (8) @(posedge clock);
            if (i >= 8)
                rdata[lsb ? i - 8 : 15 - i] = spi_sdio_in;
            spi_sclk <= 1'b1;
            repeat (8) @(posedge clock);
            spi_sclk <= 1'b0;
        end
        repeat (8) @(posedge clock);
        spi_csb_n <= 1'b1;
        drv <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
endmodule
`default_nettype wire

//--- verif/dcirq_regs_monitor.sv
// Port checker for the converter control and interrupt register bank.
// Assumes it is bound to dcirq_regs and that clock is the only domain.
`default_nettype none
module dcirq_regs_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_csb_n,
    input wire logic spi_sdio_out,
    input wire logic spi_sdio_oe,
    input wire logic frame_pin,
    input wire logic lsb_first,
    input wire logic soft_reset_pulse,
    input wire logic pd_inphase_converter,
    input wire logic pd_quadrature_converter,
    input wire logic pd_data_receiver,
    input wire logic pd_whole_chip,
    input wire logic pd_sample_clock_path,
    input wire logic receiver_a,
    input wire logic frame_int,
    input wire logic interrupt_out_a,
    input wire logic interrupt_out_b
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock);
    endclocking
    property p_rst_pd;
        rst |=> pd_inphase_converter && pd_quadrature_converter;
    endproperty
    a_rst_pd: assert property (p_rst_pd) else $error("pd reset bad");
    property p_rst_out;
        rst |=> !(pd_data_receiver | pd_whole_chip | pd_sample_clock_path
            | receiver_a | lsb_first | interrupt_out_a | interrupt_out_b
            | spi_sdio_oe);
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset bad");
    property p_pulse_one;
        disable iff (rst) soft_reset_pulse |=> !soft_reset_pulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("pulse");
    property p_soft_effect;
        disable iff (rst) soft_reset_pulse |-> ##[1:3] (pd_inphase_converter
            && pd_quadrature_converter && !lsb_first && !pd_whole_chip);
    endproperty
    a_soft_effect: assert property (p_soft_effect) else $error("soft");
    property p_csb_release;
        disable iff (rst) $rose(spi_csb_n) |-> ##[1:6] !spi_sdio_oe;
    endproperty
    a_csb_release: assert property (p_csb_release) else $error("oe");
    property p_sdio_hold;
        disable iff (rst) spi_sclk && $past(spi_sclk) && spi_sdio_oe
            |-> $stable(spi_sdio_out);
    endproperty
    a_sdio_hold: assert property (p_sdio_hold) else $error("sdio");
    property p_frame_forced;
        disable iff (rst) receiver_a && $past(receiver_a)
            && $past(receiver_a, 2) |-> !frame_int;
    endproperty
    a_frame_forced: assert property (p_frame_forced) else $error("fr");
    property p_frame_pass;
        disable iff (rst) (frame_pin && !receiver_a) [*5] |-> frame_int;
    endproperty
    a_frame_pass: assert property (p_frame_pass) else $error("frp");
endmodule
`default_nettype wire

//--- verif/dcirq_regs_tb.sv
// Self-checking bench for the converter control and interrupt registers.
// Assumes dcirq_regs, the host model and the port checker are compiled.
`default_nettype none
module dcirq_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock;
    logic       rst;
    logic [8:0] evt;
    logic [2:0] fifo_level;
    logic       frame_pin;
    logic       lsb;
    int         n_errors;
    int         n_compared;
    int         n_pulse;
    wire logic  spi_sclk, spi_csb_n, spi_sdio_in, spi_sdio_out, spi_sdio_oe;
    wire logic  lsb_first, soft_reset_pulse, frame_int, receiver_a;
    wire logic  interrupt_out_a, interrupt_out_b;
    wire logic  pd_inphase_converter, pd_quadrature_converter;
    wire logic  pd_data_receiver, pd_whole_chip, pd_sample_clock_path;
    wire logic [5:0] pd = {pd_inphase_converter, pd_quadrature_converter,
        pd_data_receiver, pd_whole_chip, pd_sample_clock_path, receiver_a};
    dcirq_regs dcirq_regs_inst (
        .clock, .rst, .spi_sclk, .spi_csb_n, .spi_sdio_in, .spi_sdio_out,
        .spi_sdio_oe, .evt_sync_lost(evt[6]), .evt_sync_locked(evt[5]),
        .evt_sync_done(evt[4]), .evt_pll_lost(evt[3]),
        .evt_pll_locked(evt[2]), .evt_over_threshold(evt[1]),
        .evt_output_muted(evt[0]), .evt_fifo_underflow(evt[8]),
        .evt_fifo_overflow(evt[7]), .fifo_level, .frame_pin, .lsb_first,
        .soft_reset_pulse, .pd_inphase_converter, .pd_quadrature_converter,
        .pd_data_receiver, .pd_whole_chip, .pd_sample_clock_path,
        .receiver_a, .frame_int, .interrupt_out_a, .interrupt_out_b);
    dcirq_host dcirq_host_inst (.clock, .spi_sclk, .spi_csb_n, .spi_sdio_in,
        .spi_sdio_out, .spi_sdio_oe);
    always #25 clock = ~clock;
    always @(posedge clock)
        if (soft_reset_pulse === 1'b1) n_pulse <= n_pulse + 1;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        dcirq_host_inst.xfer(1'b0, a, d, lsb, q);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        dcirq_host_inst.xfer(1'b1, a, 8'h00, lsb, q);
        check(q, e);
    endtask
    task automatic end_of_test();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_reset_values();
        rdc(7'h00, 8'h00);
        rdc(7'h01, 8'hC0);
        rdc(7'h03, 8'h00);
        rdc(7'h04, 8'h00);
        rdc(7'h05, 8'h00);
        check(pd, 8'h30);
    endtask
    task automatic t_power();
        frame_pin <= 1'b1;
        repeat (6) @(posedge clock);
        check(frame_int, 8'h01);
        wr(7'h01, 8'hFF);
        check(pd, 8'h3F);
        check(frame_int, 8'h00);
        rdc(7'h01, 8'hE7);
        wr(7'h01, 8'h82);
        check(pd, 8'h22);
        wr(7'h02, 8'hFF);
        rdc(7'h02, 8'h00);
        frame_pin <= 1'b0;
        wr(7'h01, 8'h01);
        check(pd, 8'h01);
    endtask
    task automatic t_events();
        int i;
        wr(7'h03, 8'h7F);
        wr(7'h04, 8'h07);
        for (i = 0; i < 9; i++) begin
            evt <= 9'h001 << i;
            @(posedge clock);
            evt <= 9'h000;
            repeat (2) @(posedge clock);
            check({interrupt_out_a, interrupt_out_b}, 8'h02);
            rdc(i < 7 ? 7'h05 : 7'h06, 8'h01 << (i < 7 ? i : i - 6));
            wr(i < 7 ? 7'h05 : 7'h06, 8'h01 << (i < 7 ? i : i - 6));
            check(interrupt_out_a, 8'h00);
        end
        wr(7'h07, 8'h7F);
        wr(7'h08, 8'h07);
        evt <= 9'h1FF;
        @(posedge clock);
        evt <= 9'h000;
        repeat (2) @(posedge clock);
        check({interrupt_out_a, interrupt_out_b}, 8'h01);
        rdc(7'h05, 8'h7F);
        rdc(7'h06, 8'h06);
        wr(7'h03, 8'h00);
        wr(7'h04, 8'h00);
        check(interrupt_out_b, 8'h00);
        wr(7'h05, 8'h7F);
        wr(7'h06, 8'h07);
        for (i = 0; i < 8; i++) begin
            fifo_level <= i[2:0];
            repeat (3) @(posedge clock);
            fifo_level <= 3'h3;
            rdc(7'h06, (i <= 1 || i >= 6) ? 8'h01 : 8'h00);
            wr(7'h06, 8'h01);
        end
    endtask
    task automatic t_bit_order();
        wr(7'h00, 8'h40);
        check(lsb_first, 8'h01);
        lsb = 1'b1;
        rdc(7'h00, 8'h40);
        wr(7'h01, 8'h82);
        check(pd, 8'h22);
        rdc(7'h01, 8'h82);
        wr(7'h00, 8'h00);
        check(lsb_first, 8'h00);
        lsb = 1'b0;
        rdc(7'h00, 8'h00);
    endtask
    task automatic t_soft_reset();
        int p0;
        wr(7'h03, 8'h55);
        p0 = n_pulse;
        wr(7'h00, 8'h20);
        check(n_pulse - p0, 8'h01);
        rdc(7'h00, 8'h00);
        rdc(7'h01, 8'hC0);
        rdc(7'h03, 8'h00);
    endtask
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        evt = 9'h000;
        fifo_level = 3'h3;
        frame_pin = 1'b0;
        lsb = 1'b0;
        n_errors = 0;
        n_compared = 0;
        n_pulse = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        t_reset_values();
        t_power();
        t_events();
        t_bit_order();
        t_soft_reset();
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        end_of_test();
    end
endmodule
bind dcirq_regs dcirq_regs_monitor dcirq_regs_monitor_inst (
    .clock, .rst, .spi_sclk, .spi_csb_n, .spi_sdio_out, .spi_sdio_oe,
    .frame_pin, .lsb_first, .soft_reset_pulse, .pd_inphase_converter,
    .pd_quadrature_converter, .pd_data_receiver, .pd_whole_chip,
    .pd_sample_clock_path, .receiver_a, .frame_int, .interrupt_out_a,
    .interrupt_out_b);
`default_nettype wire
